// *** hw/qhecd_pkg.sv ***
// package: field layout and encodings of the queue-head capability words
package qhecd_pkg;
    // capabilities word field positions
    localparam int QHECD_MULT_HI = 31;
    localparam int QHECD_MULT_LO = 30;
    localparam int QHECD_PORT_HI = 29;
    localparam int QHECD_PORT_LO = 23;
    localparam int QHECD_HUB_HI = 22;
    localparam int QHECD_HUB_LO = 16;
    localparam int QHECD_CMASK_HI = 15;
    localparam int QHECD_CMASK_LO = 8;
    localparam int QHECD_SMASK_HI = 7;
    localparam int QHECD_SMASK_LO = 0;
    // characteristics word speed field
    localparam int QHECD_EPS_HI = 13;
    localparam int QHECD_EPS_LO = 12;
    localparam int QHECD_WORD_W = 32;
    localparam int QHECD_ADDR_W = 7;
    localparam int QHECD_MASK_W = 8;
    localparam int QHECD_UFI_W = 3;
    localparam int QHECD_MULT_W = 2;

    typedef enum logic [1:0] {
        QHECD_SPD_FULL = 2'h0,
        QHECD_SPD_LOW = 2'h1,
        QHECD_SPD_HIGH = 2'h2,
        QHECD_SPD_RSVD = 2'h3
    } qhecd_speed_t;

    typedef enum logic [1:0] {
        QHECD_TX_NONE = 2'h0,
        QHECD_TX_PID = 2'h1,
        QHECD_TX_SSPLIT = 2'h2,
        QHECD_TX_CSPLIT = 2'h3
    } qhecd_txkind_t;

    localparam logic [QHECD_WORD_W-1:0] QHECD_WORD_RST = 32'h0000_0000;
    localparam logic [QHECD_MASK_W-1:0] QHECD_MASK_RST = 8'h00;

    // bit select of a micro-frame mask by the low frame index bits
    function automatic logic qhecd_mask_hit(input logic [7:0] mask, input logic [2:0] ufi);
        qhecd_mask_hit = mask[ufi];
    endfunction : qhecd_mask_hit
endpackage : qhecd_pkg

// *** hw/qhecd_speed_dec.sv ***
// speed decoder for the endpoint speed field
`timescale 1ns/10ps
module qhecd_speed_dec (
    input wire logic [1:0] endpoint_speed_i,
    output logic split_o,
    output logic high_o,
    output logic rsvd_o
);
    import qhecd_pkg::*;
    always_comb begin
        split_o = (endpoint_speed_i == QHECD_SPD_FULL) || (endpoint_speed_i == QHECD_SPD_LOW); // RQ15
        high_o = (endpoint_speed_i == QHECD_SPD_HIGH); // RQ15
        rsvd_o = (endpoint_speed_i == QHECD_SPD_RSVD); // RQ15
    end
endmodule : qhecd_speed_dec

// *** hw/qhecd_mask_sel.sv ***
// micro-frame mask selector
`timescale 1ns/10ps
module qhecd_mask_sel (
    input wire logic [7:0] smask_i,
    input wire logic [7:0] cmask_i,
    input wire logic [2:0] ufi_i,
    output logic s_hit_o,
    output logic c_hit_o,
    output logic s_nz_o,
    output logic c_nz_o
);
    import qhecd_pkg::*;
    always_comb begin
        s_hit_o = qhecd_mask_hit(smask_i, ufi_i); // RQ9
        c_hit_o = qhecd_mask_hit(cmask_i, ufi_i); // RQ7
        s_nz_o = |smask_i; // RQ10
        c_nz_o = |cmask_i;
    end
endmodule : qhecd_mask_sel

// *** hw/qhecd_top.sv ***
// queue-head endpoint capability decode, top level
`timescale 1ns/10ps
// Contract
// RQ1 - multiplier field gives packets per micro-frame: one or two etc.
// RQ2 - software never programs multiplier zero; value is reserved.
// RQ3 - multiplier applied unchecked regardless of schedule or run-time state.
// RQ4 - hub port used for splits only when speed is full or low.
// RQ5 - hub address used for splits, ignored for high-speed endpoints.
// RQ6 - complete mask ignored unless full/low speed and periodic list.
// RQ7 - frame index low bits pick complete mask bit; with active, split state.
// RQ8 - software must not leave complete mask zero for periodic full/low.
// RQ9 - start mask indexed by frame index low bits for every speed.
// RQ10 - non-zero start mask marks the queue head as interrupt endpoint.
// RQ11 - software should clear start mask on asynchronous schedule queue heads.
// RQ12 - high-speed selected head takes transaction type from packet id code.
// RQ13 - non-zero start mask with full/low speed means interrupt split transaction.
// RQ14 - software must not put zero start mask heads in periodic list.
// RQ15 - speed field decodes full, low, high; fourth value reserved.
// RQ16 - characteristics and capabilities words are read only, never written back.
module qhecd_top (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [qhecd_pkg::QHECD_WORD_W-1:0] char_word_i,
    input wire logic [qhecd_pkg::QHECD_WORD_W-1:0] cap_word_i,
    input wire logic periodic_i,
    input wire logic active_i,
    input wire logic split_phase_state_i,
    input wire logic [1:0] packet_id_code_i,
    input wire logic [qhecd_pkg::QHECD_UFI_W-1:0] frame_index_counter_i,
    output logic [qhecd_pkg::QHECD_MULT_W-1:0] mult_o,
    output logic [qhecd_pkg::QHECD_ADDR_W-1:0] hub_port_o,
    output logic [qhecd_pkg::QHECD_ADDR_W-1:0] hub_addr_o,
    output logic split_o,
    output logic speed_rsvd_o,
    output logic interrupt_ep_o,
    output logic ss_candidate_o,
    output logic cs_candidate_o,
    output qhecd_pkg::qhecd_txkind_t tx_kind_o,
    output logic [1:0] tx_pid_o
);
    import qhecd_pkg::*;

    // ****************************************
    // state
    // ****************************************
    // only a copy of the capabilities word and the speed field is kept; nothing is ever written back to memory
    typedef struct packed {
        logic [QHECD_WORD_W-1:0] cap;
        logic [1:0] endpoint_speed;
        logic [1:0] mult;
        logic [QHECD_ADDR_W-1:0] port;
        logic [QHECD_ADDR_W-1:0] hub;
        logic split;
        logic rsvd;
        logic intr;
        logic ss;
        logic cs;
        qhecd_txkind_t kind;
        logic [1:0] pid;
    } qhecd_state_t;

    qhecd_state_t st_r;
    qhecd_state_t st_nxt;
    logic is_split;
    logic is_high;
    logic is_rsvd;
    logic s_hit;
    logic c_hit;
    logic s_nz;
    logic c_nz;
    logic cmask_valid;
    logic [QHECD_MULT_W-1:0] f_mult;
    logic [QHECD_ADDR_W-1:0] f_port;
    logic [QHECD_ADDR_W-1:0] f_hub;
    logic [QHECD_MASK_W-1:0] f_cmask;
    logic [QHECD_MASK_W-1:0] f_smask;
    logic [1:0] f_eps;
    logic [QHECD_ADDR_W-1:0] g_port;
    logic [QHECD_ADDR_W-1:0] g_hub;
    logic cs_hit;
    logic ss_high;
    logic ss_split;
    qhecd_txkind_t kind_sel;

    // ****************************************
    // reset image
    // ****************************************
    // every output but split_o and tx_pid_o reads zero until the first load has landed
    localparam qhecd_state_t QHECD_ST_RST = '{
        cap: QHECD_WORD_RST,
        endpoint_speed: 2'h0,
        mult: 2'h0,
        port: 7'h00,
        hub: 7'h00,
        split: 1'h0,
        rsvd: 1'h0,
        intr: 1'h0,
        ss: 1'h0,
        cs: 1'h0,
        kind: QHECD_TX_NONE,
        pid: 2'h0
    };

    // ****************************************
    // field cuts
    // ****************************************
    // each field is cut in one place, by the package positions
    function automatic logic [QHECD_MULT_W-1:0] qhecd_mult_of(
        input logic [QHECD_WORD_W-1:0] w
    );
        qhecd_mult_of = w[QHECD_MULT_HI:QHECD_MULT_LO];
    endfunction : qhecd_mult_of

    function automatic logic [QHECD_ADDR_W-1:0] qhecd_port_of(
        input logic [QHECD_WORD_W-1:0] w
    );
        qhecd_port_of = w[QHECD_PORT_HI:QHECD_PORT_LO];
    endfunction : qhecd_port_of

    function automatic logic [QHECD_ADDR_W-1:0] qhecd_hub_of(
        input logic [QHECD_WORD_W-1:0] w
    );
        qhecd_hub_of = w[QHECD_HUB_HI:QHECD_HUB_LO];
    endfunction : qhecd_hub_of

    function automatic logic [QHECD_MASK_W-1:0] qhecd_cmask_of(
        input logic [QHECD_WORD_W-1:0] w
    );
        qhecd_cmask_of = w[QHECD_CMASK_HI:QHECD_CMASK_LO];
    endfunction : qhecd_cmask_of

    function automatic logic [QHECD_MASK_W-1:0] qhecd_smask_of(
        input logic [QHECD_WORD_W-1:0] w
    );
        qhecd_smask_of = w[QHECD_SMASK_HI:QHECD_SMASK_LO];
    endfunction : qhecd_smask_of

    // speed sits in the characteristics word, not the capabilities word
    function automatic logic [1:0] qhecd_eps_of(
        input logic [QHECD_WORD_W-1:0] w
    );
        qhecd_eps_of = w[QHECD_EPS_HI:QHECD_EPS_LO];
    endfunction : qhecd_eps_of

    // ****************************************
    // helpers
    // ****************************************
    // hub fields mean nothing to a high-speed head; zeroed so stale bits never leak out
    function automatic logic [QHECD_ADDR_W-1:0] qhecd_gate_addr(
        input logic en,
        input logic [QHECD_ADDR_W-1:0] val
    );
        if (en) begin
            qhecd_gate_addr = val;
        end else begin
            qhecd_gate_addr = '0;
        end
    endfunction : qhecd_gate_addr

    // all conditions together; a zero mask is undefined, so it never qualifies
    function automatic logic qhecd_cs_ok(
        input logic valid,
        input logic nz,
        input logic hit,
        input logic act,
        input logic phase
    );
        qhecd_cs_ok = valid && nz && hit && act && phase;
    endfunction : qhecd_cs_ok

    // start split only for full/low heads that carry an interrupt schedule
    function automatic logic qhecd_ss_ok(
        input logic hit,
        input logic spl,
        input logic nz
    );
        qhecd_ss_ok = hit && spl && nz;
    endfunction : qhecd_ss_ok

    // complete split wins over a start-mask hit in the same micro-frame
    // limitation: a reserved speed never gets a start-side kind
    function automatic qhecd_txkind_t qhecd_pick_kind(
        input logic cs,
        input logic hs,
        input logic fs
    );
        qhecd_txkind_t k;
        k = QHECD_TX_NONE;
        if (cs) begin
            k = QHECD_TX_CSPLIT;
        end else if (hs) begin
            k = QHECD_TX_PID;
        end else if (fs) begin
            k = QHECD_TX_SSPLIT;
        end
        qhecd_pick_kind = k;
    endfunction : qhecd_pick_kind

    // ****************************************
    // fields of the stored words
    // ****************************************
    // the mask, hub and multiplier fields read the stored copy; the speed field is cut from the fetch bus at load
    assign f_mult = qhecd_mult_of(st_r.cap);
    assign f_port = qhecd_port_of(st_r.cap);
    assign f_hub = qhecd_hub_of(st_r.cap);
    assign f_cmask = qhecd_cmask_of(st_r.cap);
    assign f_smask = qhecd_smask_of(st_r.cap);
    assign f_eps = qhecd_eps_of(char_word_i);

    // ****************************************
    // hub fields
    // ****************************************
    // hub fields zeroed when not a split endpoint
    assign g_port = qhecd_gate_addr(is_split, f_port); // RQ4
    assign g_hub = qhecd_gate_addr(is_split, f_hub); // RQ5

    // ****************************************
    // micro-frame qualifiers
    // ****************************************
    // complete mask only meaningful for periodic full/low heads
    assign cmask_valid = is_split && periodic_i; // RQ6
    assign cs_hit = qhecd_cs_ok(cmask_valid, c_nz, c_hit, active_i, split_phase_state_i); // RQ7
    // high speed hands the transaction type to the packet id code
    assign ss_high = s_hit && is_high; // RQ12
    assign ss_split = qhecd_ss_ok(s_hit, is_split, s_nz); // RQ13
    assign kind_sel = qhecd_pick_kind(cs_hit, ss_high, ss_split);

    // ****************************************
    // decoders
    // ****************************************
    qhecd_speed_dec u_spd (
        .endpoint_speed_i(st_r.endpoint_speed),
        .split_o(is_split),
        .high_o(is_high),
        .rsvd_o(is_rsvd)
    );

    qhecd_mask_sel u_msk (
        .smask_i(f_smask),
        .cmask_i(f_cmask),
        .ufi_i(frame_index_counter_i),
        .s_hit_o(s_hit),
        .c_hit_o(c_hit),
        .s_nz_o(s_nz),
        .c_nz_o(c_nz)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        // capture only; the words in memory are never written back
        if (load_i) begin
            st_nxt.cap = cap_word_i; // RQ16
            st_nxt.endpoint_speed = f_eps;
        end

        // static decode of the stored words; multiplier passed through unchecked
        st_nxt.mult = f_mult; // RQ1 RQ3
        st_nxt.split = is_split;
        // a reserved speed is flagged and otherwise left alone
        st_nxt.rsvd = is_rsvd; // RQ15
        st_nxt.port = g_port; // RQ4
        st_nxt.hub = g_hub; // RQ5
        st_nxt.intr = s_nz; // RQ10

        // per micro-frame decisions, one edge behind their inputs
        st_nxt.ss = s_hit; // RQ9
        st_nxt.cs = cs_hit; // RQ7
        st_nxt.pid = packet_id_code_i; // RQ12
        st_nxt.kind = kind_sel; // RQ12 RQ13
    end

    // ****************************************
    // register
    // ****************************************
    // async clear loads the constant reset image only
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= QHECD_ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // every output comes straight from a flip-flop
    assign mult_o = st_r.mult;
    assign hub_port_o = st_r.port;
    assign hub_addr_o = st_r.hub;
    assign split_o = st_r.split;
    assign speed_rsvd_o = st_r.rsvd;
    assign interrupt_ep_o = st_r.intr;
    assign ss_candidate_o = st_r.ss;
    assign cs_candidate_o = st_r.cs;
    assign tx_kind_o = st_r.kind;
    assign tx_pid_o = st_r.pid;
endmodule : qhecd_top

// *** tb/qhecd_sw_model.sv ***
// partner model: software building the queue-head capability words
`timescale 1ns/10ps
module qhecd_sw_model (
    input wire logic periodic_i,
    input wire logic [1:0] speed_i,
    input wire logic [31:0] raw_i,
    output logic [31:0] char_o,
    output logic [31:0] cap_o
);
    // software repairs its own words before the controller fetches them
    always_comb begin
        char_o = {18'h0, speed_i, 12'h000};
        cap_o = raw_i;
        if (raw_i[31:30] == 2'h0) cap_o[31:30] = 2'h1;
        if (!periodic_i) cap_o[7:0] = 8'h00;
        else if (raw_i[7:0] == 8'h00) cap_o[7:0] = 8'h01;
        if (periodic_i && !speed_i[1] && raw_i[15:8] == 8'h00) cap_o[15:8] = 8'h01;
    end
endmodule : qhecd_sw_model

// *** tb/qhecd_checker.sv ***
// checker: timing relations of the capability decode outputs
`timescale 1ns/10ps
module qhecd_checker (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [31:0] char_word_i,
    input wire logic [31:0] cap_word_i,
    input wire logic periodic_i,
    input wire logic active_i,
    input wire logic split_phase_state_i,
    input wire logic [1:0] packet_id_code_i,
    input wire logic [2:0] frame_index_counter_i,
    input wire logic [1:0] mult_o,
    input wire logic [6:0] hub_port_o,
    input wire logic [6:0] hub_addr_o,
    input wire logic split_o,
    input wire logic speed_rsvd_o,
    input wire logic interrupt_ep_o,
    input wire logic ss_candidate_o,
    input wire logic cs_candidate_o,
    input wire logic [1:0] tx_pid_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    mult_copy_a: assert property (load_i |=> ##1 mult_o == $past(cap_word_i[31:30], 2))
        else $error("multiplier not copied");
    port_gate_a: assert property (load_i |=> ##1 hub_port_o ==
        ($past(char_word_i[13], 2) ? 7'h00 : $past(cap_word_i[29:23], 2))) else $error("hub port");
    addr_gate_a: assert property (load_i |=> ##1 hub_addr_o ==
        ($past(char_word_i[13], 2) ? 7'h00 : $past(cap_word_i[22:16], 2))) else $error("hub addr");
    speed_dec_a: assert property (load_i |=> ##1 split_o == !$past(char_word_i[13], 2) &&
        speed_rsvd_o == &$past(char_word_i[13:12], 2)) else $error("speed decode");
    intr_ep_a: assert property (load_i |=> ##1 interrupt_ep_o == |$past(cap_word_i[7:0], 2))
        else $error("interrupt endpoint");
    smask_pick_a: assert property (load_i |=> ##1 ss_candidate_o ==
        |(($past(cap_word_i[7:0], 2) >> $past(frame_index_counter_i)) & 8'h01)) else $error("ss");
    cmask_pick_a: assert property (load_i |=> ##1 cs_candidate_o == (!$past(char_word_i[13], 2)
        && $past(periodic_i) && $past(active_i) && $past(split_phase_state_i) &&
        |(($past(cap_word_i[15:8], 2) >> $past(frame_index_counter_i)) & 8'h01))) else $error("cs");
    pid_copy_a: assert property (load_i |=> tx_pid_o == $past(packet_id_code_i))
        else $error("pid copy");
    cover property (load_i ##2 cs_candidate_o);
    cover property (load_i ##2 ss_candidate_o);
    cover property (load_i ##2 speed_rsvd_o);
endmodule : qhecd_checker
bind qhecd_top qhecd_checker u_chk (.clk_sys_i, .rst_n_i, .load_i, .char_word_i, .cap_word_i,
    .periodic_i, .active_i, .split_phase_state_i, .packet_id_code_i, .frame_index_counter_i,
    .mult_o, .hub_port_o, .hub_addr_o, .split_o, .speed_rsvd_o, .interrupt_ep_o,
    .ss_candidate_o, .cs_candidate_o, .tx_pid_o);

// *** tb/qhecd_top_tb.sv ***
// testbench: table cases, hub fields and reset of the capability decode
`timescale 1ns/10ps
module qhecd_top_tb;
    import qhecd_pkg::*;
    logic clk = 1'h0, rst_n = 1'h0, load = 1'h0, per = 1'h0, act = 1'h0, sps = 1'h0;
    logic [1:0] spd = 2'h0, pid = 2'h0, mult, pido;
    logic [2:0] fic = 3'h0;
    logic [31:0] raw = 32'h0, chw, capw;
    logic [6:0] hp, ha;
    logic spl, rsv, intr, ss, cs;
    qhecd_txkind_t kind;
    int mismatches = 0, n_checks = 0;
    // per, speed, raw word, index, active, split phase, then ss, cs, kind
    logic [43:0] rows [8] = '{
        {1'h1, 2'h2, 32'h4085_0004, 3'h2, 1'h1, 1'h1, 1'h1, 1'h0, 2'h1},
        {1'h1, 2'h0, 32'h8185_0C30, 3'h3, 1'h1, 1'h1, 1'h0, 1'h1, 2'h3},
        {1'h1, 2'h0, 32'h8185_0C30, 3'h4, 1'h1, 1'h1, 1'h1, 1'h0, 2'h2},
        {1'h1, 2'h1, 32'h8185_0C30, 3'h2, 1'h0, 1'h1, 1'h0, 1'h0, 2'h0},
        {1'h0, 2'h0, 32'h8185_0C30, 3'h4, 1'h1, 1'h1, 1'h0, 1'h0, 2'h0},
        {1'h1, 2'h3, 32'h4000_0020, 3'h5, 1'h1, 1'h1, 1'h1, 1'h0, 2'h0},
        {1'h0, 2'h0, 32'h8185_0C30, 3'h3, 1'h1, 1'h1, 1'h0, 1'h0, 2'h0},
        {1'h1, 2'h2, 32'h4085_0C04, 3'h2, 1'h1, 1'h1, 1'h1, 1'h0, 2'h1}};
    qhecd_sw_model u_sw (.periodic_i(per), .speed_i(spd), .raw_i(raw), .char_o(chw), .cap_o(capw));
    qhecd_top u_dut (.clk_sys_i(clk), .rst_n_i(rst_n), .load_i(load), .char_word_i(chw),
        .cap_word_i(capw), .periodic_i(per), .active_i(act), .split_phase_state_i(sps),
        .packet_id_code_i(pid), .frame_index_counter_i(fic), .mult_o(mult), .hub_port_o(hp),
        .hub_addr_o(ha), .split_o(spl), .speed_rsvd_o(rsv), .interrupt_ep_o(intr),
        .ss_candidate_o(ss), .cs_candidate_o(cs), .tx_kind_o(kind), .tx_pid_o(pido));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one load pulse, then one edge so inputs land in the candidates
    task run();
        load = 1'h1;
        @(posedge clk) #1;
        load = 1'h0;
        @(posedge clk) #1;
    endtask : run
    task end_sim();
        if (mismatches == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #20000;
        mismatches++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'h1;
        foreach (rows[i]) begin
            {per, spd, raw, fic, act, sps} = rows[i][43:4];
            run();
            chk({7'h0, ss}, {7'h0, rows[i][3]});
            chk({7'h0, cs}, {7'h0, rows[i][2]});
            chk({6'h0, kind}, {6'h0, rows[i][1:0]});
        end
        {per, spd, raw, pid} = {1'h1, 2'h2, 32'h4085_0004, 2'h2};
        run();
        chk({1'h0, hp}, 8'h00);
        chk({1'h0, ha}, 8'h00);
        chk({6'h0, pido}, 8'h02);
        spd = 2'h1;
        run();
        chk({1'h0, hp}, 8'h01);
        chk({1'h0, ha}, 8'h05);
        chk({6'h0, mult}, 8'h01);
        chk({5'h0, spl, rsv, intr}, 8'h05);
        rst_n = 1'h0;
        #1;
        chk({mult, spl, rsv, intr, ss, cs, 1'h0}, 8'h00);
        end_sim();
    end
endmodule : qhecd_top_tb
